// *** dv/cst_front_model.sv ***
`default_nettype none
// ---------------------------------------------------------------
// analog front end and pin model
// ---------------------------------------------------------------
module cst_front_model (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [3:0] req,
	input wire logic [15:0] code,
	output logic [3:0] pins,
	output logic [15:0] adc
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt [4];

	// a request gives a four cycle high pulse, wide enough to sync
	always_ff @(posedge CLK or negedge RESETN) begin
		for (int i = 0; i < 4; i++) begin
			if (!RESETN) begin
				cnt[i] <= 3'h0;
			end else if (req[i]) begin
				cnt[i] <= 3'h4;
			end else if (cnt[i] != 3'h0) begin
				cnt[i] <= cnt[i] - 3'h1;
			end
		end
	end

	// pin levels: 0 trigger, 1 first event, 2 second event, 3 line0
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pins[i] = (cnt[i] != 3'h0);
		end
	end

	assign adc = code; // converter holds one code steady
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`default_nettype none
// ---------------------------------------------------------------
// capture sequencer testbench
// ---------------------------------------------------------------
module tb_top
	import cst_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] req = 4'h0;
	logic [15:0] code = 16'h0000;
	logic [3:0] pins;
	logic [15:0] adc;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] s_data;
	logic [1:0] s_ev;
	logic s_valid;
	logic s_post;
	logic [15:0] chan_en;
	logic [15:0] dio_out;
	logic irq;
	int mismatches = 0;
	int total_checks = 0;
	int nsmp = 0;
	int nmark = 0;
	int npost = 0;
	logic [15:0] last = 16'h0000;

	cst_front_model i_cst_front_model (.CLK(CLK), .RESETN(RESETN),
		.req(req), .code(code), .pins(pins), .adc(adc));

	cst_capture_seq i_cst_capture_seq (.CLK(CLK), .RESETN(RESETN),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .TRIG_IN(pins[0]), .FIRST_EVENT_IN(pins[1]),
		.SECOND_EVENT_IN(pins[2]), .DIGITAL_INPUT_LINE0(pins[3]),
		.ADC_DATA(adc), .SAMPLE_DATA(s_data), .SAMPLE_EVENT(s_ev),
		.SAMPLE_VALID(s_valid), .SAMPLE_POST(s_post),
		.CHAN_ENABLE(chan_en), .DIO_OUT(dio_out), .IRQ(irq));

	// clock
	initial begin
		forever #12.5 CLK = ~CLK;
	end

	// sample stream monitor
	always @(posedge CLK) begin
		if (s_valid === 1'b1) begin
			nsmp++;
			last = s_data;
			if (s_ev !== 2'b00) begin
				nmark++;
			end
			if (s_post === 1'b1) begin
				npost++;
			end
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one apb transfer, answer taken at the ready edge, then one idle cycle
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge CLK);
		pen <= 1'b1;
		@(posedge CLK);
		while (pready !== 1'b1) begin
			@(posedge CLK);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge CLK);
	endtask

	task automatic wrc(input logic [7:0] a, input logic [31:0] d,
		input logic ee);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
		chk({31'h0, e}, {31'h0, ee});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q & m, exp);
	endtask

	task automatic pulse(input int i);
		req[i] <= 1'b1;
		@(posedge CLK);
		req[i] <= 1'b0;
		repeat (8) @(posedge CLK);
	endtask

	task automatic clr();
		@(negedge CLK);
		nsmp = 0;
		nmark = 0;
		npost = 0;
		@(posedge CLK);
	endtask

	task automatic t_reset();
		rd(OFS_CHAN, 32'hffff, 32'h0);
		rd(OFS_MODE, 32'hffff_ffff, 32'h0);
		rd(OFS_CLKDIV, 32'h1_ffff, 32'h1);
		rd(OFS_DIO, 32'hffff, 32'h0);
		rd(OFS_INT_MASK, 32'hf, 32'h0);
		rd(8'h20, 32'hffff_ffff, 32'h0);
		wrc(8'h20, 32'h1, 1'b1);
		chk({31'h0, irq}, 32'h0);
	endtask

	task automatic t_trig();
		wrc(OFS_INT_MASK, 32'h4, 1'b0);
		wrc(OFS_CHAN, 32'h3, 1'b0);
		wrc(OFS_MODE, 32'h0002_0007, 1'b0);
		wrc(OFS_CMD, 32'h1, 1'b0);
		clr();
		repeat (10) @(posedge CLK);
		chk(nsmp, 0);
		rd(OFS_CMD, 32'h3, 32'h1);
		pulse(0);
		rd(OFS_CMD, 32'h3, 32'h2);
		pulse(1);
		repeat (10) @(posedge CLK);
		rd(OFS_CMD, 32'h3, 32'h0);
		chk(npost, 2);
		chk(nmark, 1);
		chk({31'h0, irq}, 32'h1);
		rd(OFS_INT_STAT, 32'h4, 32'h4);
		chk({31'h0, irq}, 32'h0);
	endtask

	task automatic t_or();
		wrc(OFS_MODE, 32'h0001_000d, 1'b0);
		pulse(2);
		clr();
		wrc(OFS_CMD, 32'h1, 1'b0);
		repeat (5) @(posedge CLK);
		rd(OFS_CMD, 32'h3, 32'h2);
		chk(nmark, 0);
		pulse(2);
		repeat (5) @(posedge CLK);
		rd(OFS_CMD, 32'h3, 32'h0);
		chk(npost, 1);
	endtask

	task automatic t_refuse();
		wrc(OFS_MODE, 32'h0, 1'b0);
		wrc(OFS_CMD, 32'h1, 1'b0);
		wrc(OFS_CHAN, 32'h5, 1'b1);
		wrc(OFS_MODE, 32'h1, 1'b1);
		wrc(OFS_CMD, 32'h1, 1'b1);
		wrc(OFS_DIO, 32'ha5, 1'b0);
		chk({16'h0, dio_out}, 32'ha5);
		rd(OFS_CHAN, 32'hffff, 32'h3);
		rd(OFS_INT_STAT, 32'h8, 32'h8);
		wrc(OFS_CMD, 32'h2, 1'b0);
		rd(OFS_CMD, 32'h3, 32'h0);
		wrc(OFS_CHAN, 32'h5, 1'b0);
		chk({16'h0, chan_en}, 32'h5);
	endtask

	task automatic t_deriv();
		code <= 16'h8000;
		wrc(OFS_CLKDIV, 32'h0001_000a, 1'b0);
		wrc(OFS_CMD, 32'h1, 1'b0);
		clr();
		for (int i = 0; i < 8; i++) begin
			pulse(3);
		end
		chk(nsmp, 0);
		pulse(3);
		chk(nsmp, 1);
		chk({16'h0, last}, 32'h8000);
		rd(OFS_DATA, 32'h3_ffff, 32'h8000);
		wrc(OFS_CMD, 32'h2, 1'b0);
	endtask

	// main sequence
	initial begin
		repeat (16) @(posedge CLK);
		RESETN <= 1'b1;
		repeat (4) @(posedge CLK);
		t_reset();
		t_trig();
		t_or();
		t_refuse();
		t_deriv();
		tally_and_finish();
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge CLK);
		mismatches++;
		tally_and_finish();
	end
endmodule
`default_nettype wire

// *** logic/cst_capture_seq.sv ***
// The address map and the APB register port were decided locally.
`default_nettype none
// Function
// - each sample leaves as a signed 16-bit two's-complement word.
// - the code is passed raw so volts equal code times full scale / 32768.
// - with trigger gating nothing is stored until the trigger fires.
// - an event edge is marked on the sample taken in its cycle, else on the next sample.
// - event edges before capture has started are dropped.
// - in pre/post mode a qualifying event moves capture to post phase.
// - with both events enabled the first one to come makes the move.
// - trigger starts capture, a later event goes to post then halts.
// - while stopped all setting writes are taken in any order.
// - while not stopped only abort, digital output and interrupt mask writes are taken.
// - derived clock with divisor 10 ticks on the 9th input edge.
module cst_capture_seq
	import cst_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic TRIG_IN,
	input wire logic FIRST_EVENT_IN,
	input wire logic SECOND_EVENT_IN,
	input wire logic DIGITAL_INPUT_LINE0,
	input wire logic [15:0] ADC_DATA,
	output logic [15:0] SAMPLE_DATA,
	output logic [1:0] SAMPLE_EVENT,
	output logic SAMPLE_VALID,
	output logic SAMPLE_POST,
	output logic [15:0] CHAN_ENABLE,
	output logic [15:0] DIO_OUT,
	output logic IRQ
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		cst_state_e st;
		logic [15:0] chan;
		logic [31:0] mode;
		logic [16:0] clkdiv;
		logic [15:0] dio;
		logic [15:0] div_cnt;
		logic [15:0] post_cnt;
		logic [1:0] pend;
		logic [15:0] s_data;
		logic [1:0] s_evt;
		logic s_valid;
		logic s_post;
		logic [15:0] nsamp;
		logic [3:0] istat;
		logic [3:0] imask;
		logic [31:0] rdata;
		logic [3:0] rd_clr;
	} cst_regs_s;

	cst_regs_s r;
	cst_regs_s next_r;

	logic [3:0] pin_q, pin_rise, iset, iclr;
	logic [15:0] adc_q, term, nxt_cnt;
	logic [1:0] pend_c, ev_q;
	logic wr, idle, running, src_edge, tick, refused, mapped, abort_wr;
	logic [31:0] rmux;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	// trigger, both events and the derived clock line
	cst_sync #(
		.W(4)
	) u_pins (
		.clk(CLK),
		.resetn(RESETN),
		.d({DIGITAL_INPUT_LINE0, SECOND_EVENT_IN, FIRST_EVENT_IN,
			TRIG_IN}),
		.q(pin_q),
		.rise(pin_rise)
	);

	// converter data word
	cst_sync #(
		.W(16)
	) u_adc (
		.clk(CLK),
		.resetn(RESETN),
		.d(ADC_DATA),
		.q(adc_q),
		.rise()
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.s_valid = 1'b0;
		iset = 4'h0;
		iclr = 4'h0;
		rmux = 32'h0000_0000;
		wr = PSEL && PENABLE && PWRITE;
		idle = (r.st == ST_IDLE);
		running = (r.st == ST_RUN) || (r.st == ST_POST);

		// sample tick from divided clock or divided line edges
		src_edge = r.clkdiv[CLK_EXT_BIT] ? pin_rise[3] : 1'b1;
		term = (r.clkdiv[15:0] > 16'h0001) ?
			r.clkdiv[15:0] - 16'h0001 : 16'h0000;
		nxt_cnt = (r.div_cnt == term) ? 16'h0000 :
			r.div_cnt + 16'h0001;
		tick = running && src_edge && (nxt_cnt == term);
		if (!running) begin
			next_r.div_cnt = 16'h0000;
		end else if (src_edge) begin
			next_r.div_cnt = nxt_cnt;
		end

		// events count only once capture runs
		pend_c = running ? (r.pend | pin_rise[2:1]) : 2'b00;
		ev_q = pend_c & r.mode[MODE_EV_LSB +: 2];
		next_r.pend = tick ? 2'b00 : pend_c;

		// sample word with its event marks
		if (tick) begin
			next_r.s_valid = 1'b1;
			next_r.s_data = adc_q;
			next_r.s_evt = pend_c;
			next_r.s_post = (r.st == ST_POST);
			next_r.nsamp = r.nsamp + 16'h0001;
			iset[INT_EVENT_BIT] = |pend_c;
		end

		// capture sequence
		unique case (r.st)
			ST_IDLE: begin
				next_r.pend = 2'b00;
			end
			ST_WAIT_TRIG: begin
				if (pin_rise[0]) begin
					next_r.st = ST_RUN;
					iset[INT_TRIG_BIT] = 1'b1;
				end
			end
			ST_RUN: begin
				if (tick && r.mode[MODE_PREPOST_BIT] && |ev_q) begin
					next_r.st = ST_POST;
					next_r.post_cnt = 16'h0000;
				end
			end
			ST_POST: begin
				if (tick) begin
					next_r.post_cnt = r.post_cnt + 16'h0001;
					if (r.post_cnt + 16'h0001 >=
						r.mode[MODE_LEN_LSB +: 16]) begin
						next_r.st = ST_IDLE;
						iset[INT_DONE_BIT] = 1'b1;
					end
				end
			end
		endcase

		// address decode
		mapped = (PADDR == OFS_CMD) || (PADDR == OFS_CHAN) ||
			(PADDR == OFS_MODE) || (PADDR == OFS_CLKDIV) ||
			(PADDR == OFS_DIO) || (PADDR == OFS_DATA) ||
			(PADDR == OFS_INT_STAT) || (PADDR == OFS_INT_MASK);
		abort_wr = wr && (PADDR == OFS_CMD) && PWDATA[CMD_ABORT_BIT];

		// setting writes refused outside the stopped state
		refused = wr && !idle && ((PADDR == OFS_CHAN) ||
			(PADDR == OFS_MODE) || (PADDR == OFS_CLKDIV) ||
			((PADDR == OFS_CMD) && PWDATA[CMD_ARM_BIT] &&
			!PWDATA[CMD_ABORT_BIT]));
		iset[INT_REFUSE_BIT] = refused;

		// register writes
		if (wr && !refused) begin
			unique case (PADDR)
				OFS_CMD: begin
					if (PWDATA[CMD_ABORT_BIT]) begin
						next_r.st = ST_IDLE;
						next_r.pend = 2'b00;
					end else if (PWDATA[CMD_ARM_BIT]) begin
						next_r.st = r.mode[MODE_TRIG_BIT] ?
							ST_WAIT_TRIG : ST_RUN;
						next_r.nsamp = 16'h0000;
					end
				end
				OFS_CHAN: next_r.chan = PWDATA[15:0];
				OFS_MODE: next_r.mode = PWDATA;
				OFS_CLKDIV: next_r.clkdiv = PWDATA[16:0];
				OFS_DIO: next_r.dio = PWDATA[15:0];
				OFS_INT_MASK: next_r.imask = PWDATA[3:0];
				default: begin
				end
			endcase
		end

		// read data mux, latched in the setup cycle
		unique case (PADDR)
			OFS_CMD: rmux = {r.nsamp, 13'h0000, r.st == ST_POST, r.st};
			OFS_CHAN: rmux = {16'h0000, r.chan};
			OFS_MODE: rmux = r.mode;
			OFS_CLKDIV: rmux = {15'h0000, r.clkdiv};
			OFS_DIO: rmux = {16'h0000, r.dio};
			OFS_DATA: rmux = {14'h0000, r.s_evt, r.s_data};
			OFS_INT_STAT: rmux = {28'h000_0000, r.istat};
			OFS_INT_MASK: rmux = {28'h000_0000, r.imask};
			default: rmux = 32'h0000_0000;
		endcase
		if (PSEL && !PENABLE && !PWRITE) begin
			next_r.rdata = rmux;
			next_r.rd_clr = (PADDR == OFS_INT_STAT) ? r.istat : 4'h0;
		end
		if (PSEL && PENABLE && !PWRITE) begin
			iclr = r.rd_clr;
			next_r.rd_clr = 4'h0;
		end

		// sticky status, a new event beats the read clear
		next_r.istat = (r.istat & ~iclr) | iset;
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.chan <= RST_CHAN;
			r.mode <= RST_MODE;
			r.clkdiv <= RST_CLKDIV;
			r.dio <= RST_DIO;
			r.imask <= RST_INT_MASK;
		end else begin
			r <= next_r;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign PRDATA = r.rdata;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && (!mapped || refused);
	assign SAMPLE_DATA = r.s_data;
	assign SAMPLE_EVENT = r.s_evt;
	assign SAMPLE_VALID = r.s_valid;
	assign SAMPLE_POST = r.s_post;
	assign CHAN_ENABLE = r.chan;
	assign DIO_OUT = r.dio;
	assign IRQ = |(r.istat & r.imask); // level while unmasked bit set

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	// sample word is the synchronised converter code
	property p_word;
		tick |=> SAMPLE_VALID && SAMPLE_DATA == $past(adc_q);
	endproperty
	a_word: assert property (p_word)
		else $error("sample word differs from converter code");
	// code is not rescaled
	property p_raw;
		SAMPLE_VALID |-> $signed(SAMPLE_DATA) == $signed($past(adc_q));
	endproperty
	a_raw: assert property (p_raw)
		else $error("sample code was altered");
	// no samples while waiting for trigger
	property p_gate;
		r.st == ST_WAIT_TRIG && !abort_wr ##1 r.st == ST_WAIT_TRIG
			|-> !SAMPLE_VALID;
	endproperty
	a_gate: assert property (p_gate)
		else $error("sample stored before trigger");
	// first event edge on a tick marks that very sample
	property p_mark;
		running && tick && pin_rise[1] |=> SAMPLE_VALID && SAMPLE_EVENT[0];
	endproperty
	a_mark: assert property (p_mark)
		else $error("event mark missing on its sample");
	// first sample after a stopped cycle only carries fresh edges
	property p_ignore;
		!running |=> r.pend == 2'b00 && !SAMPLE_VALID ##1
			!(SAMPLE_VALID && SAMPLE_EVENT != 2'b00 &&
			$past(pin_rise[2:1]) == 2'b00);
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("event before capture was kept");
	// qualifying event moves to post
	property p_prepost;
		r.st == ST_RUN && tick && r.mode[MODE_PREPOST_BIT] && |ev_q &&
			!abort_wr |=> r.st == ST_POST;
	endproperty
	a_prepost: assert property (p_prepost)
		else $error("no move to post phase");
	// second event alone also moves when both enabled
	property p_or;
		r.st == ST_RUN && tick && r.mode[MODE_PREPOST_BIT] &&
			r.mode[MODE_EV_LSB +: 2] == 2'b11 && pend_c == 2'b10 &&
			!abort_wr |=> r.st == ST_POST;
	endproperty
	a_or: assert property (p_or)
		else $error("or of events did not move to post");
	// post phase ends in stop after its length
	property p_halt;
		r.st == ST_POST && tick && !abort_wr &&
			r.post_cnt + 16'h0001 >= r.mode[MODE_LEN_LSB +: 16]
			|=> r.st == ST_IDLE && r.istat[INT_DONE_BIT];
	endproperty
	a_halt: assert property (p_halt)
		else $error("post phase did not halt");
	// stopped state takes channel select
	property p_accept;
		idle && wr && PADDR == OFS_CHAN
			|=> CHAN_ENABLE == $past(PWDATA[15:0]);
	endproperty
	a_accept: assert property (p_accept)
		else $error("setting write lost while stopped");
	// mode write refused while running
	property p_refuse;
		!idle && wr && PADDR == OFS_MODE |-> PSLVERR ##1 $stable(r.mode);
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("mode changed while capturing");
	// divide by ten ticks on ninth line edge
	property p_div;
		r.st == ST_RUN && r.clkdiv == 17'h1_000a && pin_rise[3] &&
			r.div_cnt == 16'h0008 |-> tick ##1 SAMPLE_VALID;
	endproperty
	a_div: assert property (p_div)
		else $error("derived clock tick not on ninth edge");
	// abort always stops
	property p_abort;
		abort_wr |=> r.st == ST_IDLE;
	endproperty
	a_abort: assert property (p_abort)
		else $error("abort did not stop capture");

	c_post: cover property (r.st == ST_RUN ##1 r.st == ST_POST);
	c_done: cover property (r.st == ST_POST ##1 r.st == ST_IDLE);
	c_mark: cover property (SAMPLE_VALID && SAMPLE_EVENT != 2'b00);
	c_refuse: cover property (refused);

endmodule
`default_nettype wire

// *** logic/cst_pkg.sv ***
`default_nettype none
// ---------------------------------------------------------------
// capture sequencer shared constants
// ---------------------------------------------------------------
package cst_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_CHAN = 8'h04;
	localparam logic [7:0] OFS_MODE = 8'h08;
	localparam logic [7:0] OFS_CLKDIV = 8'h0c;
	localparam logic [7:0] OFS_DIO = 8'h10;
	localparam logic [7:0] OFS_DATA = 8'h14;
	localparam logic [7:0] OFS_INT_STAT = 8'h18;
	localparam logic [7:0] OFS_INT_MASK = 8'h1c;

	// command register fields
	localparam int CMD_ARM_BIT = 0;
	localparam int CMD_ABORT_BIT = 1;
	localparam int STAT_POST_BIT = 2;
	localparam int STAT_NSAMP_LSB = 16;

	// capture mode fields
	localparam int MODE_PREPOST_BIT = 0;
	localparam int MODE_TRIG_BIT = 1;
	localparam int MODE_EV_LSB = 2;
	localparam int MODE_LEN_LSB = 16;

	// clock divider fields
	localparam int CLK_EXT_BIT = 16;

	// data register fields
	localparam int DATA_EV_LSB = 16;

	// interrupt status bits
	localparam int INT_TRIG_BIT = 0;
	localparam int INT_EVENT_BIT = 1;
	localparam int INT_DONE_BIT = 2;
	localparam int INT_REFUSE_BIT = 3;

	// reset values
	localparam logic [15:0] RST_CHAN = 16'h0000;
	localparam logic [31:0] RST_MODE = 32'h0000_0000;
	localparam logic [16:0] RST_CLKDIV = 17'h0_0001;
	localparam logic [15:0] RST_DIO = 16'h0000;
	localparam logic [3:0] RST_INT_MASK = 4'h0;

	// capture states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT_TRIG,
		ST_RUN,
		ST_POST
	} cst_state_e;

endpackage
`default_nettype wire

// *** logic/cst_sync.sv ***
`default_nettype none
// ---------------------------------------------------------------
// two flop synchroniser with rising edge detect
// ---------------------------------------------------------------
module cst_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic [W-1:0] rise
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] last;
	} cst_sync_s;

	cst_sync_s r;
	cst_sync_s next_r;

	// shift chain, meta is read only by sync
	always_comb begin
		next_r.meta = d;
		next_r.sync = r.meta;
		next_r.last = r.sync;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q = r.sync;
	assign rise = r.sync & ~r.last; // one cycle per rising edge

endmodule
`default_nettype wire
